// ===== hdl/sspc_core.sv
// Synchronous serial port core: divider, frame engine, queues and status
// Operation
// - System clock first divided by an even prescale, 2 to 254.
// - Then divided by one plus clock rate field; bit clock is product.
// - Transmit queue 16 bits by 8; each write pushes unless full, engine pops.
// - Slave with empty queue sends eighth latest write, or zero.
// - Received words registered and pushed to 16x8 receive queue.
// - Four events, raw and masked status, ORed into one request.
// - Each source reaches the request only when its mask bit is 1.
// - Word size 4 to 16 bits, most significant bit first.
// - SPI and control-word frame select active low whole frame.
// - Pulse format: one period frame pulse, drive rise, sample fall.
// - Pulse format idle low, data tristated; queued data starts frame.
// - Pulse format: word goes to receive queue after last bit.
// - Control-word: 8 bit message, one wait clock, 4-16 reply bits.
// - SPI idle clock level follows the polarity bit.
// - SPI capture on first edge, phase 0; second edge, phase 1.
// - SPI mode 0 idle: clock low, select high, data low; pad by role.
// - Master: select low, data half period later, clock after another.
// - Select returns high one period after the final capture.
// - Back-to-back phase 0 words: select pulses high between words.
// - Works as master making clock and select, or as slave.
`timescale 1ns/10ps
module sspc_core
    import sspc_pkg::*;
#(
    parameter int TIMEOUT_CYC = RX_TIMEOUT_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 port_enable,
    input  wire logic                 master_mode,
    input  wire logic [1:0]           frame_format,
    input  wire logic                 clock_polarity,
    input  wire logic                 clock_phase,
    input  wire logic [SIZE_W-1:0]    data_size_m1,
    input  wire logic [7:0]           prescale_divisor,
    input  wire logic [7:0]           serial_clock_rate,
    input  wire logic [IRQ_N-1:0]     irq_mask,
    input  wire logic [IRQ_N-1:0]     irq_clear,
    input  wire logic                 tx_wr,
    input  wire logic [DATA_W-1:0]    tx_wdata,
    output logic                      tx_full,
    input  wire logic                 rx_rd,
    output logic      [DATA_W-1:0]    rx_rdata,
    output logic                      rx_empty,
    output logic      [IRQ_N-1:0]     raw_irq_status,
    output logic      [IRQ_N-1:0]     masked_irq_status,
    output logic                      irq,
    output logic                      busy,
    input  wire logic                 serial_bit_clock_i,
    output logic                      serial_bit_clock_o,
    output logic                      serial_bit_clock_oe,
    input  wire logic                 frame_select_i,
    output logic                      frame_select_o,
    output logic                      frame_select_oe,
    input  wire logic                 serial_data_in,
    output logic                      serial_data_out,
    output logic                      serial_data_out_oe
);
    localparam int CW = $clog2(FIFO_DEPTH);
    localparam logic [CNT_W-1:0] CTRL_C = CNT_W'(CTRL_BITS);
    localparam logic [CNT_W-1:0] RX_FROM_C = CNT_W'(CTRL_BITS + WAIT_BITS);
    localparam logic [CW:0] TXL_C = (CW+1)'(TX_SERVICE_LVL);
    localparam logic [CW:0] RXL_C = (CW+1)'(RX_SERVICE_LVL);
    localparam logic [15:0] TO_C = 16'(TIMEOUT_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Queues
    logic [DATA_W-1:0] tx_head, tx_hist, rx_head, rx_word;
    logic [CW:0]       tx_cnt, rx_cnt;
    logic              tx_full_w, tx_empty_w, rx_full_w, rx_empty_w;
    logic              tx_pop, rx_push, rx_pop;

    sspc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
        .clk(ref_clk), .rst(rst), .push(tx_wr), .push_data(tx_wdata), .pop(tx_pop),
        .head(tx_head), .count(tx_cnt), .full(tx_full_w), .empty(tx_empty_w), .hist(tx_hist)
    );
    sspc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxq (
        .clk(ref_clk), .rst(rst), .push(rx_push), .push_data(rx_word), .pop(rx_pop),
        .head(rx_head), .count(rx_cnt), .full(rx_full_w), .empty(rx_empty_w), .hist()
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    logic [2:0] sy1_r, sy2_r, syp_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sy1_r <= '0;
            sy2_r <= '0;
            syp_r <= '0;
        end else begin
            sy1_r <= {serial_data_in, frame_select_i, serial_bit_clock_i};
            sy2_r <= sy1_r;
            syp_r <= sy2_r;
        end
    end
    logic s_clk, s_clk_p, s_fss, s_din;
    assign s_clk   = sy2_r[0];
    assign s_clk_p = syp_r[0];
    assign s_fss   = sy2_r[1];
    assign s_din   = sy2_r[2];

    ////////////////////////////////////////////////////////////////////////
    // Format decode
    logic pol_eff, sample_first, is_spi, is_pulse, is_ctrl;
    logic [CNT_W-1:0] word_len, frame_len;
    always_comb begin
        is_spi       = (frame_format == SSPC_FMT_SPI);
        is_pulse     = (frame_format == SSPC_FMT_PULSE);
        is_ctrl      = (frame_format == SSPC_FMT_CTRL);
        pol_eff      = is_spi & clock_polarity;
        sample_first = is_spi ? !clock_phase : !is_pulse;
        word_len     = CNT_W'(data_size_m1) + 1'b1;
        frame_len    = is_ctrl ? word_len + RX_FROM_C : word_len;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit rate divider: half period = (prescale / 2) * (1 + rate)
    logic [6:0] pre_r, pre_nxt, pre_top;
    logic [7:0] scr_r, scr_nxt;
    logic       half_tick;
    sspc_state_e state_r, state_nxt;
    always_comb begin
        // Odd or too small values fall back to the nearest legal even divisor
        pre_top   = (prescale_divisor < 8'(PRESCALE_MIN)) ? 7'h01 : prescale_divisor[7:1];
        half_tick = (pre_r == pre_top - 7'h01) && (scr_r == serial_clock_rate);
        pre_nxt   = (pre_r == pre_top - 7'h01) ? 7'h00 : pre_r + 7'h01;
        scr_nxt   = half_tick ? 8'h00 : ((pre_r == pre_top - 7'h01) ? scr_r + 8'h01 : scr_r);
        if (state_r == SSPC_IDLE || !master_mode) begin
            pre_nxt = 7'h00;
            scr_nxt = 8'h00;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_r <= '0;
            scr_r <= '0;
        end else begin
            pre_r <= pre_nxt;
            scr_r <= scr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame engine, shared by master and slave
    logic              half_r, half_nxt, edge2_r, edge2_nxt;
    logic [CNT_W-1:0]  bit_r, bit_nxt;
    logic [DATA_W-1:0] txs_r, txs_nxt, rxs_r, rxs_nxt;
    logic              act_r, act_nxt, fss_r, fss_nxt, dout_r, dout_nxt;
    logic              doe_r, doe_nxt, cke_r, cke_nxt, fse_r, fse_nxt;
    logic              ev1, ev2, load, fss_idle, frame_on, smp, last;
    logic [DATA_W-1:0] load_word;

    always_comb begin
        state_nxt = state_r;
        half_nxt  = half_r;
        edge2_nxt = edge2_r;
        bit_nxt   = bit_r;
        txs_nxt   = txs_r;
        rxs_nxt   = rxs_r;
        act_nxt   = act_r ^ pol_eff;
        tx_pop    = 1'b0;
        rx_push   = 1'b0;
        load      = 1'b0;
        fss_idle  = !is_pulse;
        fss_nxt   = fss_idle;
        // Slave edges come from the synchronised pin; 12x oversampling keeps them apart
        ev1       = master_mode ? (half_tick && !edge2_r) : (s_clk != s_clk_p && s_clk != pol_eff);
        ev2       = master_mode ? (half_tick && edge2_r) : (s_clk != s_clk_p && s_clk == pol_eff);
        frame_on  = is_pulse ? 1'b1 : (s_fss == 1'b0);
        smp       = (sample_first ? ev1 : ev2) && (!is_ctrl || bit_r >= RX_FROM_C);
        last      = (bit_r == frame_len - 1'b1);
        // Empty queue as slave replays the history tap
        load_word = tx_empty_w ? tx_hist : tx_head;
        if (is_ctrl) begin
            load_word = DATA_W'(load_word[CTRL_BITS-1:0]) << (DATA_W - CTRL_BITS);
        end else begin
            load_word = load_word << (DATA_W - 1 - int'(data_size_m1));
        end
        case (state_r)
            SSPC_IDLE: begin
                act_nxt = 1'b0;
                if (port_enable && master_mode && !tx_empty_w) begin
                    state_nxt = SSPC_LEAD;
                    half_nxt  = 1'b0;
                end else if (port_enable && !master_mode && frame_on) begin
                    // Pulse format slave starts on the frame pulse seen at a rising edge
                    if (!is_pulse || (ev1 && s_fss)) begin
                        load      = 1'b1;
                        state_nxt = SSPC_BITS;
                    end
                end
            end
            SSPC_LEAD: begin
                fss_nxt = !fss_idle;
                if (half_tick) begin
                    half_nxt = !half_r;
                    load = !half_r;
                    if (half_r || !is_pulse) begin
                        state_nxt = SSPC_BITS;
                        fss_nxt   = 1'b0;
                    end
                end
            end
            SSPC_BITS: begin
                fss_nxt = 1'b0;
                if (ev1) begin
                    act_nxt = 1'b1;
                    if (!sample_first && bit_r != '0) begin
                        txs_nxt = {txs_r[DATA_W-2:0], 1'b0};
                    end
                end
                if (ev2) begin
                    act_nxt = 1'b0;
                    if (sample_first) begin
                        txs_nxt = {txs_r[DATA_W-2:0], 1'b0};
                    end
                    bit_nxt = bit_r + 1'b1;
                end
                if (ev1 || ev2) begin
                    edge2_nxt = !edge2_r;
                end
                if (smp) begin
                    rxs_nxt = {rxs_r[DATA_W-2:0], s_din};
                end
                if (ev2 && last) begin
                    rx_push   = 1'b1;
                    state_nxt = master_mode ? SSPC_TAIL : ((is_spi && clock_phase) ? SSPC_IDLE : SSPC_GAP);
                    half_nxt  = sample_first;
                end
                if (!master_mode && !frame_on) begin
                    state_nxt = SSPC_IDLE; // Slave frame aborted by select
                end
            end
            SSPC_TAIL: begin
                fss_nxt = 1'b0;
                if (half_tick) begin
                    half_nxt = !half_r;
                    if (half_r) begin
                        // Select stays low for continuous SPI phase 1 and control-word words; pulse format pulses it again
                        if (!tx_empty_w && port_enable && !(is_spi && !clock_phase)) begin
                            state_nxt = SSPC_LEAD;
                        end else begin
                            state_nxt = (is_spi && !clock_phase && !tx_empty_w) ? SSPC_GAP : SSPC_IDLE;
                            fss_nxt   = fss_idle;
                        end
                    end
                end
            end
            SSPC_GAP: begin
                // Master holds select high one period; slave waits for it
                if (master_mode ? (half_tick && half_r) : s_fss) begin
                    state_nxt = SSPC_IDLE;
                end
                if (half_tick) begin
                    half_nxt = !half_r;
                end
            end
            default: state_nxt = SSPC_IDLE;
        endcase
        if (load) begin
            txs_nxt   = load_word;
            rxs_nxt   = '0;
            bit_nxt   = '0;
            edge2_nxt = 1'b0;
            tx_pop    = !tx_empty_w;
        end
        if (!port_enable && state_r != SSPC_BITS) begin
            state_nxt = SSPC_IDLE;
        end
        rx_word = rxs_nxt;
        // Pin levels; clock toggles only inside a frame
        cke_nxt  = master_mode;
        fse_nxt  = master_mode;
        dout_nxt = (state_r == SSPC_BITS || state_nxt == SSPC_BITS) ? txs_nxt[DATA_W-1] : 1'b0;
        doe_nxt  = master_mode ? !(is_pulse && state_nxt == SSPC_IDLE) : (state_nxt == SSPC_BITS);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= SSPC_IDLE;
            half_r  <= 1'b0;
            edge2_r <= 1'b0;
            bit_r   <= '0;
            txs_r   <= '0;
            rxs_r   <= '0;
            act_r   <= 1'b0;
            fss_r   <= 1'b1;
            dout_r  <= 1'b0;
            doe_r   <= 1'b0;
            cke_r   <= 1'b0;
            fse_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            half_r  <= half_nxt;
            edge2_r <= edge2_nxt;
            bit_r   <= bit_nxt;
            txs_r   <= txs_nxt;
            rxs_r   <= rxs_nxt;
            act_r   <= act_nxt ^ pol_eff;
            fss_r   <= fss_nxt;
            dout_r  <= dout_nxt;
            doe_r   <= doe_nxt;
            cke_r   <= cke_nxt;
            fse_r   <= fse_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status, timeout and host side outputs
    logic [IRQ_N-1:0]  sticky_r, sticky_nxt, raw_nxt, raw_r, msk_r;
    logic [15:0]       to_r, to_nxt;
    logic [DATA_W-1:0] rdat_r, rdat_nxt;
    logic              irq_r, txf_r, rxe_r, busy_r, ovr_ev, to_ev;
    always_comb begin
        rx_pop   = rx_rd && !rx_empty_w;
        rdat_nxt = rx_pop ? rx_head : rdat_r;
        ovr_ev   = rx_push && rx_full_w;
        // Timer runs only while data waits and the line is quiet
        if (rx_empty_w || state_r != SSPC_IDLE || s_clk != s_clk_p) begin
            to_nxt = 16'h0000;
        end else begin
            to_nxt = (to_r == TO_C) ? to_r : to_r + 16'h0001;
        end
        to_ev      = (to_r != TO_C) && (to_nxt == TO_C);
        // A new event wins over a clear in the same cycle
        sticky_nxt = sticky_r & ~irq_clear;
        sticky_nxt[IRQ_RT]  = sticky_nxt[IRQ_RT] | to_ev;
        sticky_nxt[IRQ_ROR] = sticky_nxt[IRQ_ROR] | ovr_ev;
        raw_nxt          = sticky_nxt;
        raw_nxt[IRQ_TX]  = (tx_cnt <= TXL_C);
        raw_nxt[IRQ_RX]  = (rx_cnt >= RXL_C);
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sticky_r <= '0;
            raw_r    <= '0;
            msk_r    <= '0;
            irq_r    <= 1'b0;
            to_r     <= '0;
            rdat_r   <= '0;
            txf_r    <= 1'b0;
            rxe_r    <= 1'b1;
            busy_r   <= 1'b0;
        end else begin
            sticky_r <= sticky_nxt;
            raw_r    <= raw_nxt;
            msk_r    <= raw_nxt & irq_mask;
            irq_r    <= |(raw_nxt & irq_mask);
            to_r     <= to_nxt;
            rdat_r   <= rdat_nxt;
            txf_r    <= tx_full_w;
            rxe_r    <= rx_empty_w;
            busy_r   <= (state_nxt != SSPC_IDLE);
        end
    end

    assign tx_full             = txf_r;
    assign rx_rdata            = rdat_r;
    assign rx_empty            = rxe_r;
    assign raw_irq_status      = raw_r;
    assign masked_irq_status   = msk_r;
    assign irq                 = irq_r;
    assign busy                = busy_r;
    assign serial_bit_clock_o  = act_r;
    assign serial_bit_clock_oe = cke_r;
    assign frame_select_o      = fss_r;
    assign frame_select_oe     = fse_r;
    assign serial_data_out     = dout_r;
    assign serial_data_out_oe  = doe_r;
endmodule // sspc_core

// ===== hdl/sspc_pkg.sv
// Shared constants and types for the synchronous serial port core
package sspc_pkg;
    localparam int DATA_W          = 16;   // Queue word width
    localparam int FIFO_DEPTH      = 8;    // Entries per queue
    localparam int SIZE_W          = 4;    // Width of the data size field (size minus one)
    localparam int CNT_W           = 5;    // Bit counter, holds up to a 25 bit frame
    localparam int CTRL_BITS       = 8;    // Control message length, control-word format
    localparam int WAIT_BITS       = 1;    // Turnaround clock, control-word format
    localparam int TX_SERVICE_LVL  = 4;    // Transmit service while count at or below
    localparam int RX_SERVICE_LVL  = 4;    // Receive service while count at or above
    localparam int RX_TIMEOUT_CYC  = 1024; // Idle cycles before receive timeout
    localparam int PRESCALE_MIN    = 2;    // Smallest legal prescale divisor
    localparam int PRESCALE_MAX    = 254;  // Largest legal prescale divisor

    // Interrupt source bit positions
    localparam int IRQ_TX  = 0;
    localparam int IRQ_RX  = 1;
    localparam int IRQ_RT  = 2;
    localparam int IRQ_ROR = 3;
    localparam int IRQ_N   = 4;

    typedef enum logic [1:0] {
        SSPC_FMT_SPI   = 2'h0,
        SSPC_FMT_PULSE = 2'h1,
        SSPC_FMT_CTRL  = 2'h2
    } sspc_fmt_e;

    typedef enum logic [4:0] {
        SSPC_IDLE = 5'h01,
        SSPC_LEAD = 5'h02,
        SSPC_BITS = 5'h04,
        SSPC_TAIL = 5'h08,
        SSPC_GAP  = 5'h10
    } sspc_state_e;
endpackage

// ===== hdl/sspc_fifo.sv
// Word queue with occupancy count and write history tap
`timescale 1ns/10ps
module sspc_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       push,
    input  wire logic [W-1:0]               push_data,
    input  wire logic                       pop,
    output logic      [W-1:0]               head,
    output logic      [$clog2(DEPTH):0]     count,
    output logic                            full,
    output logic                            empty,
    output logic      [W-1:0]               hist
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt, hcnt_r, hcnt_nxt;
    logic          do_push, do_pop;

    ////////////////////////////////////////////////////////////////////////
    // Pointer arithmetic; full queue drops a push, empty drops a pop
    always_comb begin
        do_push  = push && (cnt_r != DEPTH_C);
        do_pop   = pop && (cnt_r != '0);
        wp_nxt   = do_push ? wp_r + 1'b1 : wp_r;
        rp_nxt   = do_pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt  = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        hcnt_nxt = (do_push && hcnt_r != DEPTH_C) ? hcnt_r + 1'b1 : hcnt_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r   <= '0;
            rp_r   <= '0;
            cnt_r  <= '0;
            hcnt_r <= '0;
        end else begin
            wp_r   <= wp_nxt;
            rp_r   <= rp_nxt;
            cnt_r  <= cnt_nxt;
            hcnt_r <= hcnt_nxt;
        end
    end

    // Storage has no reset; history tap guards unwritten slots
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_r[wp_r] <= push_data;
        end
    end

    assign head  = mem_r[rp_r];
    assign count = cnt_r;
    assign full  = (cnt_r == DEPTH_C);
    assign empty = (cnt_r == '0);
    // Next write slot holds the eighth most recent value once eight were written
    assign hist  = (hcnt_r == DEPTH_C) ? mem_r[wp_r] : '0;
endmodule // sspc_fifo

// ===== bench/sspc_core_asserts.sv
// Checker for pin and status relations of the serial port core
`timescale 1ns/10ps
module sspc_core_asserts
    import sspc_pkg::*;
#(
    parameter int TIMEOUT_CYC = 16
) (
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic             master_mode,
    input wire logic [1:0]       frame_format,
    input wire logic             clock_polarity,
    input wire logic [IRQ_N-1:0] irq_mask,
    input wire logic             tx_wr,
    input wire logic             tx_full,
    input wire logic [IRQ_N-1:0] raw_irq_status,
    input wire logic [IRQ_N-1:0] masked_irq_status,
    input wire logic             irq,
    input wire logic             busy,
    input wire logic             serial_bit_clock_o,
    input wire logic             serial_bit_clock_oe,
    input wire logic             frame_select_o
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Outputs are registered, so idle checks wait out one cycle of lag, the select check two
    a_idle_clk_pol: assert property (frame_format == SSPC_FMT_SPI && !busy && !$past(busy)
        && $stable(clock_polarity) |-> serial_bit_clock_o == clock_polarity) else $error("idle clock level");
    a_sel_idle_high: assert property (frame_format != SSPC_FMT_PULSE && master_mode && $stable(frame_format)
        && !busy && !$past(busy) && !$past(busy, 2) |-> frame_select_o) else $error("select not idle high");
    a_pulse_idle: assert property (frame_format == SSPC_FMT_PULSE && master_mode && $stable(frame_format)
        && !busy && !$past(busy) |-> !serial_bit_clock_o && !frame_select_o) else $error("pulse idle level");
    a_clk_oe_role: assert property (!$past(rst) && $stable(master_mode)
        |-> serial_bit_clock_oe == master_mode) else $error("clock pad role");
    a_clk_quiet: assert property (master_mode && !busy && !$past(busy)
        && $past({frame_format, clock_polarity}, 2) == {frame_format, clock_polarity}
        |-> $stable(serial_bit_clock_o)) else $error("idle clock moved");
    a_tx_full_cause: assert property ($rose(tx_full) |-> $past(tx_wr) || $past(tx_wr, 2))
        else $error("full without write");
    a_mask_gate: assert property ((masked_irq_status & ~irq_mask & ~$past(irq_mask)) == 4'h0)
        else $error("masked source passed");
    a_irq_or: assert property ($stable(masked_irq_status) |-> irq == |masked_irq_status)
        else $error("request not or of sources");
endmodule // sspc_core_asserts

bind sspc_core sspc_core_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.ref_clk, .rst, .master_mode,
    .frame_format, .clock_polarity, .irq_mask, .tx_wr, .tx_full, .raw_irq_status, .masked_irq_status,
    .irq, .busy, .serial_bit_clock_o, .serial_bit_clock_oe, .frame_select_o);

// ===== bench/sspc_slave_model.sv
// Behavioural serial peripheral answering in clock mode zero
`timescale 1ns/10ps
module sspc_slave_model (
    input  wire logic        sclk,
    input  wire logic        ss_n,
    input  wire logic        mosi,
    input  wire logic [15:0] word,
    input  wire logic [3:0]  size_m1,
    output logic             miso,
    output logic [15:0]      rx_word
);
    int idx = 0;
    initial miso = 1'b0;
    // Select low puts the first bit out before any clock edge
    always @(negedge ss_n) begin
        idx = size_m1;
        rx_word = 16'h0000;
        miso = word[idx];
    end
    always @(posedge sclk) if (!ss_n) rx_word = {rx_word[14:0], mosi};
    always @(negedge sclk) if (!ss_n && idx > 0) begin
        idx--;
        miso = word[idx];
    end
    // Released line shows the inverse, never a held value
    always @(posedge ss_n) miso = ~miso;
endmodule // sspc_slave_model

// ===== bench/sspc_core_tb.sv
// Self-checking bench: queues, framing and status of the serial port core
`timescale 1ns/10ps
module sspc_core_tb;
    logic        ref_clk = 1'b0, rst = 1'b1, port_enable = 1'b0, master_mode = 1'b1;
    logic        clock_polarity = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
    logic [1:0]  frame_format = 2'h0;
    logic [3:0]  data_size_m1 = 4'h7, irq_mask = 4'h0, irq_clear = 4'h0;
    logic [7:0]  prescale_divisor = 8'h04, serial_clock_rate = 8'h01;
    logic [15:0] tx_wdata = 16'h0000, rx_rdata, slv_rx;
    logic        tx_full, rx_empty, irq, busy, sck, sck_oe, fs, fs_oe, sdo, sdo_oe, miso;
    logic [3:0]  raw_irq_status, masked_irq_status;
    logic [15:0] cap[$];
    int          err_count = 0, comparisons = 0;
    // Pad levels: pull-down on clock, pull-up on select
    wire sck_pin = sck_oe ? sck : 1'b0;
    wire fs_pin  = fs_oe ? fs : 1'b1;
    wire mosi    = sdo_oe ? sdo : 1'b0;
    sspc_core #(.TIMEOUT_CYC(16)) dut_u (.ref_clk, .rst, .port_enable, .master_mode, .frame_format,
        .clock_polarity, .clock_phase(1'b0), .data_size_m1, .prescale_divisor, .serial_clock_rate, .irq_mask,
        .irq_clear, .tx_wr, .tx_wdata, .tx_full, .rx_rd, .rx_rdata, .rx_empty, .raw_irq_status,
        .masked_irq_status, .irq, .busy, .serial_bit_clock_i(sck_pin), .serial_bit_clock_o(sck),
        .serial_bit_clock_oe(sck_oe), .frame_select_i(fs_pin), .frame_select_o(fs), .frame_select_oe(fs_oe),
        .serial_data_in(miso), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe));
    sspc_slave_model slv_u (.sclk(sck_pin), .ss_n(fs_pin), .mosi, .word(16'hC3A5), .size_m1(data_size_m1),
        .miso, .rx_word(slv_rx));
    // One word per select release
    always @(posedge fs_pin) if (!rst) cap.push_back(slv_rx);
    initial forever #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge ref_clk);
        tx_wr <= 1'b1;
        tx_wdata <= d;
        @(posedge ref_clk);
        tx_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] exp);
        @(posedge ref_clk);
        rx_rd <= 1'b1;
        @(posedge ref_clk);
        rx_rd <= 1'b0;
        @(negedge ref_clk);
        check(rx_rdata, exp);
    endtask
    // Bounded waits; running out counts as a mismatch
    task automatic wait_idle();
        int t, q;
        t = 0;
        q = 0;
        while (q < 40) begin
            @(negedge ref_clk);
            q = (busy === 1'b0) ? q + 1 : 0;
            t++;
            if (t > 8000) begin
                err_count++;
                stop_test();
            end
        end
    endtask
    task automatic wait_lvl(input logic v, inout int n);
        while (sck !== v) begin
            @(negedge ref_clk);
            n++;
            if (n > 3000) begin
                err_count++;
                stop_test();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // Fill the queue while disabled, then one write too many
        for (int i = 0; i < 8; i++) wr({8'h12, 4'(i), 4'(i)});
        repeat (2) @(negedge ref_clk);
        check(tx_full, 1'b1);
        wr(16'h00EE);
        port_enable <= 1'b1;
        wait_idle();
        check(16'(cap.size()), 16'h0008);
        foreach (cap[k]) check(cap[k], {8'h00, 4'(k), 4'(k)});
        wr(16'h0001);
        wait_idle();
        check(raw_irq_status, 4'hF);
        check(irq, 1'b0);
        @(posedge ref_clk);
        irq_mask <= 4'h8;
        repeat (3) @(negedge ref_clk);
        check({irq, masked_irq_status}, 5'h18);
        @(posedge ref_clk);
        irq_clear <= 4'hC;
        @(posedge ref_clk);
        irq_clear <= 4'h0;
        for (int i = 0; i < 8; i++) rd(16'h00A5);
        repeat (2) @(negedge ref_clk);
        check({rx_empty, irq, masked_irq_status}, 6'h20);
        // Smallest and largest word with two divider settings, odd acting as even
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            data_size_m1 <= s ? 4'hF : 4'h3;
            prescale_divisor <= s ? 8'h07 : 8'h02;
            serial_clock_rate <= s ? 8'h02 : 8'h03;
            wr(16'h9A5B);
            n = 0;
            wait_lvl(1'b1, n);
            n = 0;
            wait_lvl(1'b0, n);
            wait_lvl(1'b1, n);
            check(16'(n), s ? 16'd18 : 16'd8);
            wait_idle();
            check(cap[$], s ? 16'h9A5B : 16'h000B);
            rd(s ? 16'hC3A5 : 16'h0005);
        end
        @(posedge ref_clk);
        clock_polarity <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check(sck, 1'b1);
        @(posedge ref_clk);
        frame_format <= 2'h1;
        repeat (3) @(negedge ref_clk);
        check({sck, fs, sdo_oe}, 3'h0);
        @(posedge ref_clk);
        master_mode <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check({sck_oe, fs_oe}, 2'h0);
        stop_test();
    end
endmodule // sspc_core_tb
